/* File: logic/fail_counter_sat.v */
`timescale 1ns/1ps

`include "timebase_window_watchdog_defines.vh"

module fail_counter_sat (
    // Clock and reset.
    input  wire       clk_in,
    input  wire       rst_n_in,
    // Events.
    input  wire       enable_in,
    input  wire       good_in,
    input  wire       bad_in,
    // Count.
    output reg  [2:0] count_out
);

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_out <= `FC_RESET;
        end else if (enable_in) begin
            if (bad_in && (count_out != `FC_MAX)) begin
                count_out <= count_out + 3'h1;
            end else if (good_in && !bad_in && (count_out != `FC_MIN)) begin
                count_out <= count_out - 3'h1;
            end
        end
    end

endmodule // fail_counter_sat

/* File: logic/timebase_window_watchdog.v */
`timescale 1ns/1ps

`include "timebase_window_watchdog_defines.vh"

// How it works
// - A free 32-bit timebase counts up by one every clock.
// - Timebase clears on reset and when the watchdog becomes enabled.
// - The timebase register returns all 32 count bits.
// - Control/status zero carries timebase bits 31..4 with enable and status bits.
// - Timebase interrupt pulses one clock when the count wraps to zero.
// - Watchdog interval is two to a fixed build-time width, 8 to 31.
// - First expiry raises the watchdog interrupt and sets the state flag.
// - Writing one clears the state flag; expiry while still set resets.
// - A watchdog reset sets a reset-status flag for software.
// - Legacy-mode disabling needs both enable bits cleared, at two distinct addresses; window mode uses only the CSR0 bit.
// - After expiry only the bus reset restarts the watchdog.
// - Window mode: closed then open window; open-window action is good.
// - Closed-window restart or disable is bad and the watchdog stays on.
// - Open window ending without action is a bad event.
// - Sequence monitor compares the two signatures at restart; mismatch is bad.
// - Sequence monitor works only with its bit set, in window mode.
// - Second sequence timer, when enabled, delays the final reset.
// - Fail counter steps down on good, up on bad, saturating at 0 and 7.
// - Fail counter resets to five.
// - Bad event at count seven resets, at once or after the delay timer.
// - Without the fail counter any bad event resets.
// - Window-mode reset clears the enable bit and waits for bus reset.
// - Reset-pending output follows its flag while the delay timer runs.
// - In window mode the interrupt output follows the window interrupt flag.
module timebase_window_watchdog #(
    parameter WDT_WIDTH = `WDT_WIDTH_DEF
) (
    // Clock and reset.
    input  wire        sys_clk_in,
    input  wire        rst_n_in,
    // AXI4-Lite write address and data.
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // AXI4-Lite write response.
    output wire [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read.
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Watchdog outputs.
    output reg         timebase_irq_out,
    output wire        wdt_interrupt_out,
    output reg         wdt_reset_out,
    output reg         wdt_reset_pending_out
);

    // ****************************************
    // Reset release.
    // ****************************************
    reg                 rst_s1_q;
    reg                 rst_n_q;

    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // ****************************************
    // Bus handshake.
    // ****************************************
    wire                wr_en;
    wire                rd_en;
    wire [31:0]         wmask;
    wire                lane0;

    assign wr_en         = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    assign s_axi_awready = wr_en;
    assign s_axi_wready  = wr_en;
    assign rd_en         = s_axi_arvalid & ~s_axi_rvalid;
    assign s_axi_arready = rd_en;
    assign s_axi_bresp   = `RESP_OKAY;
    assign s_axi_rresp   = `RESP_OKAY;
    assign lane0         = s_axi_wstrb[0];

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_mask
            assign wmask[gi*8 +: 8] = {8{s_axi_wstrb[gi]}};
        end
    endgenerate

    wire wr_csr0   = wr_en & (s_axi_awaddr == `OFS_CSR0);
    wire wr_csr1   = wr_en & (s_axi_awaddr == `OFS_CSR1);
    wire wr_cfg    = wr_en & (s_axi_awaddr == `OFS_WIN_CFG);
    wire wr_first  = wr_en & (s_axi_awaddr == `OFS_FIRST_WIN);
    wire wr_second = wr_en & (s_axi_awaddr == `OFS_SECOND_WIN);
    wire wr_sst    = wr_en & (s_axi_awaddr == `OFS_SST_LIMIT);
    wire wr_sig0   = wr_en & (s_axi_awaddr == `OFS_SIG_INIT);
    wire wr_sig1   = wr_en & (s_axi_awaddr == `OFS_SIG_DONE);
    wire wr_stat   = wr_en & (s_axi_awaddr == `OFS_WIN_STAT);

    // ****************************************
    // State registers.
    // ****************************************
    reg  [31:0]          tb_q;
    reg  [WDT_WIDTH-1:0] wdt_cnt_q;
    reg                  en_a_q;
    reg                  en_b_q;
    reg                  en_prev_q;
    reg                  state_q;
    reg                  rstat_q;
    reg                  expired_q;
    reg                  win_mode_q;
    reg                  psm_en_q;
    reg                  sst_en_q;
    reg                  fc_en_q;
    reg  [31:0]          first_q;
    reg  [31:0]          second_q;
    reg  [31:0]          sst_lim_q;
    reg  [31:0]          sig_init_q;
    reg  [31:0]          sig_done_q;
    reg                  phase_q;
    reg  [31:0]          win_cnt_q;
    reg  [31:0]          sst_cnt_q;
    reg                  irq_flag_q;
    reg                  halted_q;
    wire [2:0]           fc_count;

    // either bit keeps legacy mode running.
    wire enabled_now = win_mode_q ? en_a_q : (en_a_q | en_b_q);
    wire en_rise     = enabled_now & ~en_prev_q;

    // interval is the full span of the counter.
    wire leg_run = ~win_mode_q & enabled_now & ~expired_q;
    wire leg_exp = leg_run & (&wdt_cnt_q);

    wire win_run   = win_mode_q & en_a_q & ~halted_q;
    wire kick      = wr_csr1 & lane0 & s_axi_wdata[`CSR1_EN_BIT] & win_run;
    wire dis       = wr_csr0 & lane0 & ~s_axi_wdata[`CSR0_EN_BIT] & win_run;
    wire attempt   = kick | dis;
    // compare only with monitor bit in window mode.
    wire sig_ok    = ~psm_en_q | (sig_init_q == sig_done_q);
    wire open_exp  = win_run & (phase_q == `PHASE_OPEN) & (win_cnt_q == second_q) & ~attempt;
    wire good      = attempt & (phase_q == `PHASE_OPEN) & (dis | sig_ok);
    wire bad       = (attempt & (phase_q == `PHASE_CLOSED))
                   | (kick & (phase_q == `PHASE_OPEN) & ~sig_ok)
                   | open_exp;
    wire trigger   = bad & (fc_en_q ? (fc_count == `FC_MAX) : 1'b1);
    wire sst_done  = wdt_reset_pending_out & (sst_cnt_q == sst_lim_q);
    wire fire      = (trigger & ~wdt_reset_pending_out & ~sst_en_q) | sst_done;

    // ****************************************
    // Timebase.
    // ****************************************
    always @(posedge sys_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tb_q             <= `WORD_ZERO;
            timebase_irq_out <= 1'b0;
            en_prev_q        <= 1'b0;
        end else begin
            en_prev_q <= enabled_now;
            if (en_rise) begin
                tb_q <= `WORD_ZERO;
            end else begin
                tb_q <= tb_q + 32'h1;
            end
            timebase_irq_out <= ~en_rise & (tb_q == `TB_ALL_ONES);
        end
    end

    // ****************************************
    // Legacy watchdog and control bits.
    // ****************************************
    always @(posedge sys_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            wdt_cnt_q     <= {WDT_WIDTH{1'b0}};
            en_a_q        <= 1'b0;
            en_b_q        <= 1'b0;
            state_q       <= 1'b0;
            rstat_q       <= 1'b0;
            expired_q     <= 1'b0;
            wdt_reset_out <= 1'b0;
        end else begin
            if (en_rise || !leg_run) begin
                wdt_cnt_q <= {WDT_WIDTH{1'b0}};
            end else begin
                wdt_cnt_q <= wdt_cnt_q + {{(WDT_WIDTH-1){1'b0}}, 1'b1};
            end
            // enable bits are frozen after expiry.
            if (fire) begin
                en_a_q <= 1'b0;
            end else if (wr_csr0 && lane0 && !expired_q && !halted_q) begin
                if (!win_run || s_axi_wdata[`CSR0_EN_BIT] || phase_q == `PHASE_OPEN) begin
                    en_a_q <= s_axi_wdata[`CSR0_EN_BIT];
                end
            end
            if (wr_csr1 && lane0 && !expired_q && !win_mode_q) begin
                en_b_q <= s_axi_wdata[`CSR1_EN_BIT];
            end
            if (leg_exp) begin
                state_q <= 1'b1;
            end else if (wr_csr0 && lane0 && s_axi_wdata[`CSR0_STATE_BIT]) begin
                state_q <= 1'b0;
            end
            if (leg_exp && state_q) begin
                expired_q     <= 1'b1;
                wdt_reset_out <= 1'b1;
            end else if (fire) begin
                wdt_reset_out <= 1'b1;
            end
            if ((leg_exp && state_q) || fire) begin
                rstat_q <= 1'b1;
            end else if (wr_csr0 && lane0 && s_axi_wdata[`CSR0_RSTAT_BIT]) begin
                rstat_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // Window watchdog.
    // ****************************************
    always @(posedge sys_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            win_mode_q            <= 1'b0;
            psm_en_q              <= 1'b0;
            sst_en_q              <= 1'b0;
            fc_en_q               <= 1'b0;
            first_q               <= `WORD_ZERO;
            second_q              <= `WORD_ZERO;
            sst_lim_q             <= `WORD_ZERO;
            sig_init_q            <= `WORD_ZERO;
            sig_done_q            <= `WORD_ZERO;
            phase_q               <= `PHASE_CLOSED;
            win_cnt_q             <= `WORD_ZERO;
            sst_cnt_q             <= `WORD_ZERO;
            irq_flag_q            <= 1'b0;
            halted_q              <= 1'b0;
            wdt_reset_pending_out <= 1'b0;
        end else begin
            if (wr_cfg && lane0 && !win_run) begin
                win_mode_q <= s_axi_wdata[`CFG_WIN_BIT];
                psm_en_q   <= s_axi_wdata[`CFG_PSM_BIT];
                sst_en_q   <= s_axi_wdata[`CFG_SST_BIT];
                fc_en_q    <= s_axi_wdata[`CFG_FC_BIT];
            end
            if (wr_first) first_q <= (first_q & ~wmask) | (s_axi_wdata & wmask);
            if (wr_second) second_q <= (second_q & ~wmask) | (s_axi_wdata & wmask);
            if (wr_sst) sst_lim_q <= (sst_lim_q & ~wmask) | (s_axi_wdata & wmask);
            if (wr_sig0) sig_init_q <= (sig_init_q & ~wmask) | (s_axi_wdata & wmask);
            if (wr_sig1) sig_done_q <= (sig_done_q & ~wmask) | (s_axi_wdata & wmask);
            if (!win_run || en_rise) begin
                phase_q   <= `PHASE_CLOSED;
                win_cnt_q <= `WORD_ZERO;
            end else begin
                case (phase_q)
                    `PHASE_CLOSED: begin
                        if (win_cnt_q == first_q) begin
                            phase_q   <= `PHASE_OPEN;
                            win_cnt_q <= `WORD_ZERO;
                        end else begin
                            win_cnt_q <= win_cnt_q + 32'h1;
                        end
                    end
                    `PHASE_OPEN: begin
                        if (attempt || open_exp) begin
                            phase_q   <= `PHASE_CLOSED;
                            win_cnt_q <= `WORD_ZERO;
                        end else begin
                            win_cnt_q <= win_cnt_q + 32'h1;
                        end
                    end
                    default: begin
                        phase_q   <= `PHASE_CLOSED;
                        win_cnt_q <= `WORD_ZERO;
                    end
                endcase
            end
            if (win_run && phase_q == `PHASE_CLOSED && win_cnt_q == first_q) begin
                irq_flag_q <= 1'b1;
            end else if (wr_stat && lane0 && s_axi_wdata[`STAT_IRQ_BIT]) begin
                irq_flag_q <= 1'b0;
            end
            if (fire) begin
                wdt_reset_pending_out <= 1'b0;
                halted_q              <= win_mode_q;
            end else if (trigger && sst_en_q && !wdt_reset_pending_out) begin
                wdt_reset_pending_out <= 1'b1;
                sst_cnt_q             <= `WORD_ZERO;
            end else if (wdt_reset_pending_out) begin
                sst_cnt_q <= sst_cnt_q + 32'h1;
            end
        end
    end

    fail_counter_sat u_fail_counter (
        .clk_in    (sys_clk_in),
        .rst_n_in  (rst_n_q),
        .enable_in (fc_en_q & win_mode_q),
        .good_in   (good),
        .bad_in    (bad),
        .count_out (fc_count)
    );

    assign wdt_interrupt_out = win_mode_q ? irq_flag_q : state_q;

    // ****************************************
    // Bus responses and read data.
    // ****************************************
    always @(posedge sys_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            s_axi_bvalid <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= `WORD_ZERO;
        end else begin
            if (wr_en) begin
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (rd_en) begin
                s_axi_rvalid <= 1'b1;
                case (s_axi_araddr)
                    `OFS_CSR0: s_axi_rdata <= {tb_q[31:`CSR0_TB_LSB], 1'b0, rstat_q, state_q, en_a_q};
                    `OFS_CSR1: s_axi_rdata <= {31'h0, en_b_q};
                    `OFS_TIMEBASE:   s_axi_rdata <= tb_q;
                    `OFS_WIN_CFG:    s_axi_rdata <= {28'h0, fc_en_q, sst_en_q, psm_en_q, win_mode_q};
                    `OFS_FIRST_WIN:  s_axi_rdata <= first_q;
                    `OFS_SECOND_WIN: s_axi_rdata <= second_q;
                    `OFS_SST_LIMIT:  s_axi_rdata <= sst_lim_q;
                    `OFS_SIG_INIT:   s_axi_rdata <= sig_init_q;
                    `OFS_SIG_DONE:   s_axi_rdata <= sig_done_q;
                    `OFS_WIN_STAT:   s_axi_rdata <= {24'h0, 1'b0, fc_count, phase_q, halted_q,
                                                     wdt_reset_pending_out, irq_flag_q};
                    default:         s_axi_rdata <= `WORD_ZERO;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // timebase_window_watchdog

/* File: logic/timebase_window_watchdog_defines.vh */
`ifndef TIMEBASE_WINDOW_WATCHDOG_DEFINES_VH
`define TIMEBASE_WINDOW_WATCHDOG_DEFINES_VH

// ****************************************
// Register byte offsets.
// ****************************************
`define OFS_CSR0       8'h00
`define OFS_CSR1       8'h04
`define OFS_TIMEBASE   8'h08
`define OFS_WIN_CFG    8'h0c
`define OFS_FIRST_WIN  8'h10
`define OFS_SECOND_WIN 8'h14
`define OFS_SST_LIMIT  8'h18
`define OFS_SIG_INIT   8'h1c
`define OFS_SIG_DONE   8'h20
`define OFS_WIN_STAT   8'h24

// ****************************************
// Field positions.
// ****************************************
`define CSR0_EN_BIT    0
`define CSR0_STATE_BIT 1
`define CSR0_RSTAT_BIT 2
`define CSR0_TB_LSB    4
`define CSR1_EN_BIT    0
`define CFG_WIN_BIT    0
`define CFG_PSM_BIT    1
`define CFG_SST_BIT    2
`define CFG_FC_BIT     3
`define STAT_IRQ_BIT   0

// ****************************************
// Values and counts.
// ****************************************
`define WDT_WIDTH_DEF  30
`define TB_ALL_ONES    32'hffffffff
`define WORD_ZERO      32'h00000000
`define FC_RESET       3'h5
`define FC_MAX         3'h7
`define FC_MIN         3'h0
`define RESP_OKAY      2'h0
`define PHASE_CLOSED   1'b0
`define PHASE_OPEN     1'b1

`endif

/* File: sim/axi_lite_master_model.sv */
`timescale 1ns/1ps

module axi_lite_master_model (
    // Clock.
    input  wire        clk_in,
    // Write channels.
    output reg  [7:0]  awaddr_out,
    output reg         awvalid_out,
    input  wire        awready_in,
    output reg  [31:0] wdata_out,
    output reg  [3:0]  wstrb_out,
    output reg         wvalid_out,
    input  wire        wready_in,
    input  wire        bvalid_in,
    output reg         bready_out,
    // Read channels.
    output reg  [7:0]  araddr_out,
    output reg         arvalid_out,
    input  wire        arready_in,
    input  wire [31:0] rdata_in,
    input  wire        rvalid_in,
    output reg         rready_out
);
    initial begin
        {awaddr_out, awvalid_out, wdata_out, wvalid_out, bready_out} = 43'h0;
        {araddr_out, arvalid_out} = 9'h0;
        wstrb_out = 4'hf;
        rready_out = 1'b1;
    end

    task write_word(input [7:0] a, input [31:0] d, output reg ok);
        integer n;
        begin
            ok = 1'b0;
            awaddr_out <= a;
            wdata_out <= d;
            awvalid_out <= 1'b1;
            wvalid_out <= 1'b1;
            for (n = 0; n < 16 && !ok; n = n + 1) begin
                @(posedge clk_in);
                ok = (awready_in === 1'b1) && (wready_in === 1'b1);
            end
            awvalid_out <= 1'b0;
            wvalid_out <= 1'b0;
            @(posedge clk_in);
            bready_out <= 1'b1;
            if (ok) begin
                ok = 1'b0;
                for (n = 0; n < 16 && !ok; n = n + 1) begin
                    @(posedge clk_in);
                    ok = (bvalid_in === 1'b1) && (bready_out === 1'b1);
                end
            end
            bready_out <= 1'b0;
        end
    endtask

    task read_word(input [7:0] a, output reg [31:0] d, output reg ok);
        integer n;
        begin
            ok = 1'b0;
            araddr_out <= a;
            arvalid_out <= 1'b1;
            for (n = 0; n < 16 && !ok; n = n + 1) begin
                @(posedge clk_in);
                ok = (arready_in === 1'b1);
            end
            arvalid_out <= 1'b0;
            if (ok) begin
                ok = 1'b0;
                for (n = 0; n < 16 && !ok; n = n + 1) begin
                    @(posedge clk_in);
                    ok = (rvalid_in === 1'b1);
                end
            end
            d = rdata_in;
        end
    endtask
endmodule // axi_lite_master_model

/* File: sim/tb_timebase_window_watchdog.sv */
`timescale 1ns/1ps

`include "timebase_window_watchdog_defines.vh"

module tb_timebase_window_watchdog;
    reg          sys_clk_in;
    reg          rst_n_in;
    wire [7:0]   s_axi_awaddr, s_axi_araddr;
    wire [31:0]  s_axi_wdata, s_axi_rdata;
    wire [3:0]   s_axi_wstrb;
    wire [1:0]   s_axi_bresp, s_axi_rresp;
    wire         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    wire         s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    wire         timebase_irq_out, wdt_interrupt_out, wdt_reset_out, wdt_reset_pending_out;
    integer      err_total, checked;
    reg  [31:0]  d, e;

    timebase_window_watchdog #(.WDT_WIDTH(8)) dut (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .timebase_irq_out(timebase_irq_out),
        .wdt_interrupt_out(wdt_interrupt_out), .wdt_reset_out(wdt_reset_out),
        .wdt_reset_pending_out(wdt_reset_pending_out));

    axi_lite_master_model m (
        .clk_in(sys_clk_in), .awaddr_out(s_axi_awaddr), .awvalid_out(s_axi_awvalid),
        .awready_in(s_axi_awready), .wdata_out(s_axi_wdata), .wstrb_out(s_axi_wstrb),
        .wvalid_out(s_axi_wvalid), .wready_in(s_axi_wready), .bvalid_in(s_axi_bvalid),
        .bready_out(s_axi_bready), .araddr_out(s_axi_araddr), .arvalid_out(s_axi_arvalid),
        .arready_in(s_axi_arready), .rdata_in(s_axi_rdata), .rvalid_in(s_axi_rvalid),
        .rready_out(s_axi_rready));

    // ****************************************
    // Shared tasks.
    // ****************************************
    initial begin
        sys_clk_in = 1'b0;
        forever #12.5 sys_clk_in = ~sys_clk_in;
    end

    task check(input [31:0] got, input [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    task end_of_test;
        begin
            $display("Mismatches %0d, comparisons %0d.", err_total, checked);
            if (err_total == 0 && checked > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask

    task hang;
        begin
            err_total = err_total + 1;
            $display("CHECK FAILED at %0t: wait ran out", $time);
            end_of_test;
        end
    endtask

    task wr(input [7:0] a, input [31:0] v);
        reg ok;
        begin
            m.write_word(a, v, ok);
            if (!ok) hang;
        end
    endtask

    task rd(input [7:0] a);
        reg ok;
        begin
            m.read_word(a, d, ok);
            if (!ok) hang;
        end
    endtask

    // 0: interrupt, 1: reset, 2: pending.
    task wait_for(input integer which, input integer bound);
        integer n;
        reg     hit;
        begin
            hit = 1'b0;
            for (n = 0; n < bound && hit !== 1'b1; n = n + 1) begin
                @(posedge sys_clk_in);
                hit = which == 0 ? wdt_interrupt_out :
                      which == 1 ? wdt_reset_out : wdt_reset_pending_out;
            end
            if (hit !== 1'b1) hang;
        end
    endtask

    task do_reset;
        begin
            rst_n_in <= 1'b0;
            repeat (5) @(posedge sys_clk_in);
            rst_n_in <= 1'b1;
            repeat (4) @(posedge sys_clk_in);
        end
    endtask

    // ****************************************
    // Scenarios.
    // ****************************************
    task t_regs_timebase;
        begin
            rd(`OFS_WIN_STAT);
            check(32'(d[6:4]), 32'(`FC_RESET));
            rd(8'h3c);
            check(d, `WORD_ZERO);
            rd(`OFS_TIMEBASE);
            e = d;
            rd(`OFS_TIMEBASE);
            check(32'((d - e) >= 32'h2 && (d - e) <= 32'h8), 32'h1);
            wr(`OFS_CSR0, 32'h1);
            rd(`OFS_TIMEBASE);
            check(32'(d < 32'h10), 32'h1);
            rd(`OFS_CSR0);
            e = d;
            rd(`OFS_TIMEBASE);
            check(32'((d[31:4] - e[31:4]) <= 28'h1), 32'h1);
        end
    endtask

    task t_legacy;
        begin
            wr(`OFS_CSR1, 32'h1);
            wr(`OFS_CSR0, 32'h0);
            wait_for(0, 300);
            rd(`OFS_CSR0);
            check(32'(d[2:0]), 32'h2);
            wr(`OFS_CSR0, 32'h2);
            check(32'(wdt_interrupt_out), 32'h0);
            wait_for(0, 300);
            wait_for(1, 300);
            rd(`OFS_CSR0);
            check(32'(d[2]), 32'h1);
            wr(`OFS_CSR0, 32'h1);
            check(32'(wdt_reset_out), 32'h1);
        end
    endtask

    task t_window_fc;
        begin
            do_reset;
            wr(`OFS_FIRST_WIN, 32'h14);
            wr(`OFS_SECOND_WIN, 32'h28);
            wr(`OFS_WIN_CFG, 32'h9);
            wr(`OFS_CSR0, 32'h1);
            wr(`OFS_CSR1, 32'h1);
            rd(`OFS_WIN_STAT);
            check(32'(d[6:3]), 32'hc);
            rd(`OFS_CSR0);
            check(32'(d[0]), 32'h1);
            wait_for(0, 60);
            wr(`OFS_WIN_STAT, 32'h1);
            check(32'(wdt_interrupt_out), 32'h0);
            wr(`OFS_CSR1, 32'h1);
            rd(`OFS_WIN_STAT);
            check(32'(d[6:4]), 32'h5);
            repeat (3) wr(`OFS_CSR1, 32'h1);
            wait_for(1, 8);
            rd(`OFS_CSR0);
            check(32'(d[0]), 32'h0);
        end
    endtask

    task t_window_sst;
        begin
            do_reset;
            wr(`OFS_FIRST_WIN, 32'ha);
            wr(`OFS_SECOND_WIN, 32'ha);
            wr(`OFS_SST_LIMIT, 32'h1e);
            wr(`OFS_WIN_CFG, 32'h5);
            wr(`OFS_CSR0, 32'h1);
            wait_for(2, 40);
            check(32'(wdt_reset_out), 32'h0);
            wait_for(1, 40);
            check(32'(wdt_reset_pending_out), 32'h0);
        end
    endtask

    task t_sequence;
        begin
            do_reset;
            wr(`OFS_FIRST_WIN, 32'h5);
            wr(`OFS_SECOND_WIN, 32'hc8);
            wr(`OFS_SIG_INIT, 32'ha5);
            wr(`OFS_SIG_DONE, 32'ha5);
            wr(`OFS_WIN_CFG, 32'h3);
            wr(`OFS_CSR0, 32'h1);
            wait_for(0, 20);
            wr(`OFS_CSR1, 32'h1);
            check(32'(wdt_reset_out), 32'h0);
            wr(`OFS_WIN_STAT, 32'h1);
            wr(`OFS_SIG_DONE, 32'h5a);
            wait_for(0, 20);
            wr(`OFS_CSR1, 32'h1);
            wait_for(1, 8);
        end
    endtask

    initial begin
        err_total = 0;
        checked = 0;
        rst_n_in = 1'b0;
        do_reset;
        t_regs_timebase;
        t_legacy;
        t_window_fc;
        t_window_sst;
        t_sequence;
        end_of_test;
    end
endmodule // tb_timebase_window_watchdog

/* File: sim/timebase_window_watchdog_props.sv */
`timescale 1ns/1ps

module timebase_window_watchdog_props (
    input wire       sys_clk_in,
    input wire       rst_n_in,
    input wire       s_axi_awvalid,
    input wire       s_axi_awready,
    input wire       s_axi_wvalid,
    input wire [1:0] s_axi_bresp,
    input wire       s_axi_bvalid,
    input wire       s_axi_bready,
    input wire       s_axi_arvalid,
    input wire       s_axi_arready,
    input wire [1:0] s_axi_rresp,
    input wire       s_axi_rvalid,
    input wire       timebase_irq_out,
    input wire       wdt_reset_out,
    input wire       wdt_reset_pending_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    chk_write_answer: assert property (
        s_axi_awvalid && s_axi_wvalid && s_axi_awready |=> s_axi_bvalid && s_axi_bresp == 2'h0)
        else $error("write not okay");
    chk_write_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    chk_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write while bvalid");
    chk_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rresp == 2'h0)
        else $error("read not okay");
    chk_read_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid))
        else $error("rvalid unasked");
    chk_tb_pulse: assert property (timebase_irq_out |=> !timebase_irq_out)
        else $error("tb irq too long");
    chk_reset_sticks: assert property (wdt_reset_out |=> wdt_reset_out)
        else $error("reset released");
    chk_pending_excl: assert property (wdt_reset_pending_out |-> !wdt_reset_out)
        else $error("pending with reset");
    chk_pending_ends: assert property ($fell(wdt_reset_pending_out) |-> wdt_reset_out)
        else $error("pending no reset");
endmodule // timebase_window_watchdog_props

bind timebase_window_watchdog timebase_window_watchdog_props u_props (.*);
